// ### hfpa_host_fifo_port.sv
/*
 * Host access to the receive status, receive data, transmit status and transmit
 * data FIFOs, with size, event, level and software reset registers.
 * Assumes an asynchronous SRAM-like host bus (strobes synchronised here) and
 * MAC datapaths on clk that honour valid/ready.
 */
`timescale 1ns/10ps
`include "hfpa_map.svh"

// Behaviour
// - Writes to read-only registers change nothing.
// - Write-only registers read back as zero.
// - Writing one clears bit; zero ignored.
// - Clear-on-read bits drop after host read.
// - Latched low/high bits hold until read.
// - Soft-reset-immune bits survive software reset.
// - System reset loads every default value; software reset only the FIFOs, event bits and read port.
// - Four FIFOs exposed to the host.
// - Data and receive status sizes configurable.
// - Receive FIFOs cannot be pushed by host.
// - Receive status pop returns and removes head.
// - Receive status view returns head, keeps it.
// - Receive data read always pops the head.
// - Receive data aliased over sixteen dwords.
// - Transmit status pop returns and removes head.
// - Transmit status view returns head, keeps it.
// - Transmit data write-only; reads change nothing.
// - Transmit data aliased over sixteen dwords.
module hfpa_host_fifo_port import hfpa_pkg::*; #(
	parameter int DEPTH     = `HFPA_DEPTH,
	parameter int STS_DEPTH = `HFPA_DEPTH
) (
	input  logic              clk,
	input  logic              rst,
	input  logic              host_cs_n,
	input  logic              host_rd_n,
	input  logic              host_wr_n,
	input  logic [`HFPA_AW-1:0] host_addr,
	input  logic [`HFPA_DW-1:0] host_data_in,
	output logic [`HFPA_DW-1:0] host_data_out,
	output logic              host_data_oe,
	input  logic              link_up,
	input  logic              rx_data_valid,
	output logic              rx_data_ready,
	input  logic [`HFPA_DW-1:0] rx_data_in,
	input  logic              rx_sts_valid,
	output logic              rx_sts_ready,
	input  logic [`HFPA_DW-1:0] rx_sts_in,
	input  logic              tx_sts_valid,
	output logic              tx_sts_ready,
	input  logic [`HFPA_DW-1:0] tx_sts_in,
	output logic              tx_data_valid,
	input  logic              tx_data_ready,
	output logic [`HFPA_DW-1:0] tx_data_out,
	output logic              mac_soft_reset
);

	localparam int LW  = $clog2(DEPTH + 1);
	localparam int SLW = $clog2(STS_DEPTH + 1);

	// Limits travel in eight-bit slots; bigger FIFOs would not fit
	if (DEPTH < 2 || LW > 8 || STS_DEPTH < 2 || SLW > 8) begin : g_bad_depth
		$error("hfpa_host_fifo_port: depths must be 2 to 255");
	end

	// Pin synchronisers: bit 0 cs_n, 1 rd_n, 2 wr_n, 3 link_up
	logic [3:0]        pin_s1_ff;       // First stage, read only by stage two
	logic [3:0]        pin_s2_ff;       // Second stage, safe to use
	hfpa_req_t         req_s1_ff;       // Address and data, first stage
	hfpa_req_t         req_s2_ff;       // Address and data, second stage

	hfpa_acc_t         state_ff;        // Access sequencer
	hfpa_acc_t         nxt_state;
	hfpa_cfg_t         cfg_ff;          // Size limits, kept through soft reset
	logic              srst_ff;         // One-cycle software reset pulse
	logic [`HFPA_DW-1:0] host_data_out_ff; // Read data held for the host
	logic              host_data_oe_ff; // Bus driven during a read

	wire               clr;             // System or software reset
	wire               rd_act;          // Read strobe asserted
	wire               wr_act;          // Write strobe asserted
	wire               rd_go;           // First cycle of a read
	wire               wr_go;           // First cycle of a write
	wire [`HFPA_AW-1:0] addr;           // Synchronised byte address
	wire [`HFPA_AW-1:0] dw_addr;        // Address with byte bits dropped
	wire [`HFPA_DW-1:0] wdata;          // Synchronised write data
	wire [1:0]         win;             // Data window select
	hfpa_port_t        port_sel;        // Decoded target
	wire [`HFPA_DW-1:0] rd_val;         // Read mux result

	// FIFO handshakes
	wire               rxd_vld, rxs_vld, txs_vld, txd_rdy;
	wire [`HFPA_DW-1:0] rxd_dat, rxs_dat, txs_dat;
	wire [LW-1:0]      rxd_lvl, txd_lvl;
	wire [SLW-1:0]     rxs_lvl, txs_lvl;
	wire               rxd_pop, rxs_pop, txs_pop, txd_push;

	// Event register wiring
	wire [`HFPA_EVT_W-1:0] evt_set;
	wire [`HFPA_EVT_W-1:0] evt_bits;
	wire [`HFPA_DW-1:0]    evt_word;
	wire [`HFPA_DW-1:0]    cfg_word;
	wire [`HFPA_DW-1:0]    lvl_word;

	// FIFOs, event bits and read port fall back to their defaults on either reset
	assign clr = rst | srst_ff;

	// Two flops on every pin; reset to idle levels, so no false link event
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1_ff <= 4'hf;
			pin_s2_ff <= 4'hf;
			req_s1_ff <= '0;
			req_s2_ff <= '0;
		end else begin
			pin_s1_ff <= {link_up, host_wr_n, host_rd_n, host_cs_n};
			pin_s2_ff <= pin_s1_ff;
			req_s1_ff <= '{addr: host_addr, wdata: host_data_in};
			req_s2_ff <= req_s1_ff;
		end
	end

	// Strobes; address and data must be stable while a strobe is low
	assign rd_act  = ~pin_s2_ff[0] & ~pin_s2_ff[1];
	assign wr_act  = ~pin_s2_ff[0] & ~pin_s2_ff[2] & pin_s2_ff[1];
	assign rd_go   = (state_ff == ACC_IDLE) & rd_act;
	assign wr_go   = (state_ff == ACC_IDLE) & wr_act & ~rd_act;
	assign addr    = req_s2_ff.addr;
	assign wdata   = req_s2_ff.wdata;
	assign dw_addr = {addr[`HFPA_AW-1:2], 2'b00};
	assign win     = addr[`HFPA_WIN_HI:`HFPA_WIN_LO];

	// Address decode; both data windows span sixteen dwords
	assign port_sel =
		(win == `HFPA_WIN_RXD)       ? P_RXD :
		(win == `HFPA_WIN_TXD)       ? P_TXD :
		(dw_addr == `HFPA_RXS_POP)   ? P_RXS :
		(dw_addr == `HFPA_RXS_VIEW)  ? P_RXS_VIEW :
		(dw_addr == `HFPA_TXS_POP)   ? P_TXS :
		(dw_addr == `HFPA_TXS_VIEW)  ? P_TXS_VIEW :
		(dw_addr == `HFPA_CFG)       ? P_CFG :
		(dw_addr == `HFPA_EVT)       ? P_EVT :
		(dw_addr == `HFPA_LVL)       ? P_LVL :
		(dw_addr == `HFPA_SRST)      ? P_SRST : P_NONE;

	// Access sequencer: one action per strobe, then wait for release
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ACC_IDLE: begin
				if (rd_act) begin
					nxt_state = ACC_READ;
				end else if (wr_act) begin
					nxt_state = ACC_WRITE;
				end
			end
			ACC_READ: begin
				if (!rd_act) begin
					nxt_state = ACC_IDLE;
				end
			end
			ACC_WRITE: begin
				if (!wr_act) begin
					nxt_state = ACC_IDLE;
				end
			end
			default: begin
				nxt_state = ACC_IDLE;
			end
		endcase
	end

	// Sequencer held by system reset only, so a soft reset mid-strobe
	// cannot launch a second access from the same strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ACC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Pops happen once, on the first cycle of the read
	assign rxd_pop  = rd_go & (port_sel == P_RXD);
	assign rxs_pop  = rd_go & (port_sel == P_RXS);
	assign txs_pop  = rd_go & (port_sel == P_TXS);
	// Only the pop port drains; a view leaves the head alone
	// so the next pop returns the very same entry
	// One push per write strobe, whatever the alias
	assign txd_push = wr_go & (port_sel == P_TXD);

	// Receive data: MAC fills, host drains; host has no push path
	hfpa_fifo #(.WIDTH(`HFPA_DW), .DEPTH(DEPTH)) u_rxd (
		.clk       (clk),
		.clr       (clr),
		.limit     (cfg_ff.rxd_lim[LW-1:0]),
		.in_valid  (rx_data_valid),
		.in_ready  (rx_data_ready),
		.in_data   (rx_data_in),
		.out_valid (rxd_vld),
		.out_ready (rxd_pop),
		.out_data  (rxd_dat),
		.level     (rxd_lvl)
	);

	// Receive status: MAC fills, host pops or views
	hfpa_fifo #(.WIDTH(`HFPA_DW), .DEPTH(STS_DEPTH)) u_rxs (
		.clk       (clk),
		.clr       (clr),
		.limit     (cfg_ff.rxs_lim[SLW-1:0]),
		.in_valid  (rx_sts_valid),
		.in_ready  (rx_sts_ready),
		.in_data   (rx_sts_in),
		.out_valid (rxs_vld),
		.out_ready (rxs_pop),
		.out_data  (rxs_dat),
		.level     (rxs_lvl)
	);

	// Transmit status: fixed size, MAC fills, host pops or views
	hfpa_fifo #(.WIDTH(`HFPA_DW), .DEPTH(STS_DEPTH)) u_txs (
		.clk       (clk),
		.clr       (clr),
		.limit     ('0),
		.in_valid  (tx_sts_valid),
		.in_ready  (tx_sts_ready),
		.in_data   (tx_sts_in),
		.out_valid (txs_vld),
		.out_ready (txs_pop),
		.out_data  (txs_dat),
		.level     (txs_lvl)
	);

	// Transmit data: host fills, MAC drains and may stall
	hfpa_fifo #(.WIDTH(`HFPA_DW), .DEPTH(DEPTH)) u_txd (
		.clk       (clk),
		.clr       (clr),
		.limit     (cfg_ff.txd_lim[LW-1:0]),
		.in_valid  (txd_push),
		.in_ready  (txd_rdy),
		.in_data   (wdata),
		.out_valid (tx_data_valid),
		.out_ready (tx_data_ready),
		.out_data  (tx_data_out),
		.level     (txd_lvl)
	);

	// Event sources; link and status-full latch until the host reads
	assign evt_set[`HFPA_EVT_RXD_UNDER] = rxd_pop & ~rxd_vld;
	assign evt_set[`HFPA_EVT_TXD_DROP]  = txd_push & ~txd_rdy;
	assign evt_set[`HFPA_EVT_LINK_LOW]  = ~pin_s2_ff[3];
	assign evt_set[`HFPA_EVT_RXS_FULL]  = ~rx_sts_ready;

	// Underrun is write-one-clear; the other three clear on read
	hfpa_sticky #(
		.W        (`HFPA_EVT_W),
		.W1C_MASK (`HFPA_EVT_W1C_MASK),
		.RC_MASK  (`HFPA_EVT_RC_MASK),
		.RST_VAL  (`HFPA_EVT_RST)
	) u_evt (
		.clk     (clk),
		.clr     (clr),
		.set_ev  (evt_set),
		.wr_one  (wr_go & (port_sel == P_EVT)),
		.wr_data (wdata[`HFPA_EVT_W-1:0]),
		.rd_hit  (rd_go & (port_sel == P_EVT)),
		.bits    (evt_bits)
	);

	// Latch-low bit reads zero while latched
	assign evt_word = {{(`HFPA_DW-`HFPA_EVT_W){1'b0}}, evt_bits ^ `HFPA_EVT_INV_MASK};
	assign cfg_word = {8'h00, cfg_ff.txd_lim, cfg_ff.rxs_lim, cfg_ff.rxd_lim};
	assign lvl_word = (`HFPA_DW'(rxs_lvl) << `HFPA_LVL_RXS_LSB)
	                | (`HFPA_DW'(rxd_lvl) << `HFPA_LVL_RXD_LSB)
	                | (`HFPA_DW'(txs_lvl) << `HFPA_LVL_TXS_LSB)
	                | (`HFPA_DW'(txd_lvl) << `HFPA_LVL_TXD_LSB);

	// Read mux; empty FIFOs, write-only and unmapped ports give zero
	assign rd_val =
		(port_sel == P_RXD)                             ? (rxd_vld ? rxd_dat : '0) :
		(port_sel == P_RXS || port_sel == P_RXS_VIEW)   ? (rxs_vld ? rxs_dat : '0) :
		(port_sel == P_TXS || port_sel == P_TXS_VIEW)   ? (txs_vld ? txs_dat : '0) :
		(port_sel == P_CFG)                             ? cfg_word :
		(port_sel == P_EVT)                             ? evt_word :
		(port_sel == P_LVL)                             ? lvl_word : '0;

	// Read data captured once and held while the strobe stays low
	always_ff @(posedge clk) begin
		if (clr) begin
			host_data_out_ff <= '0;
			host_data_oe_ff  <= 1'b0;
		end else begin
			if (rd_go) begin
				host_data_out_ff <= rd_val;
			end
			host_data_oe_ff <= (nxt_state == ACC_READ);
		end
	end

	// Size limits survive a software reset; only system reset restores them
	// Level register has no write path at all
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_ff <= '{txd_lim: `HFPA_CFG_RST_LIM, rxs_lim: `HFPA_CFG_RST_LIM,
			            rxd_lim: `HFPA_CFG_RST_LIM};
		end else if (wr_go && port_sel == P_CFG) begin
			cfg_ff.rxd_lim <= wdata[`HFPA_CFG_RXD_LSB +: 8];
			cfg_ff.rxs_lim <= wdata[`HFPA_CFG_RXS_LSB +: 8];
			cfg_ff.txd_lim <= wdata[`HFPA_CFG_TXD_LSB +: 8];
		end
	end

	// Self-clearing software reset trigger, also handed to the MAC
	always_ff @(posedge clk) begin
		if (rst) begin
			srst_ff <= 1'b0;
		end else begin
			srst_ff <= wr_go & (port_sel == P_SRST) & wdata[`HFPA_SRST_BIT];
		end
	end

	assign host_data_out  = host_data_out_ff;
	assign host_data_oe   = host_data_oe_ff;
	assign mac_soft_reset = srst_ff;

endmodule

// ### hfpa_map.svh
/*
 * Address map, field positions, reset values and sizes of the host FIFO port block.
 * Assumes a dword-aligned byte address of eight bits; included by its bare name.
 */
`ifndef HFPA_MAP_SVH
`define HFPA_MAP_SVH

// Sizes
`define HFPA_DEPTH         32
`define HFPA_AW            8
`define HFPA_DW            32

// Data windows: sixteen dword aliases each, chosen by address bits 7:6
`define HFPA_WIN_HI        7
`define HFPA_WIN_LO        6
`define HFPA_WIN_RXD       2'h0
`define HFPA_WIN_TXD       2'h1

// Single-dword ports
`define HFPA_RXS_POP       8'h80
`define HFPA_RXS_VIEW      8'h84
`define HFPA_TXS_POP       8'h88
`define HFPA_TXS_VIEW      8'h8c
`define HFPA_CFG           8'h90
`define HFPA_EVT           8'h94
`define HFPA_LVL           8'h98
`define HFPA_SRST          8'h9c

// Size configuration fields, eight bits per slot
`define HFPA_CFG_RXD_LSB   0
`define HFPA_CFG_RXS_LSB   8
`define HFPA_CFG_TXD_LSB   16
`define HFPA_CFG_RST_LIM   8'h20

// Level register fields
`define HFPA_LVL_TXD_LSB   0
`define HFPA_LVL_TXS_LSB   8
`define HFPA_LVL_RXD_LSB   16
`define HFPA_LVL_RXS_LSB   24

// Event register bits and attribute masks
`define HFPA_EVT_W         4
`define HFPA_EVT_RXD_UNDER 0
`define HFPA_EVT_TXD_DROP  1
`define HFPA_EVT_LINK_LOW  2
`define HFPA_EVT_RXS_FULL  3
`define HFPA_EVT_W1C_MASK  4'h1
`define HFPA_EVT_RC_MASK   4'he
`define HFPA_EVT_INV_MASK  4'h4
`define HFPA_EVT_RST       4'h0

// Software reset trigger bit
`define HFPA_SRST_BIT      0

`endif

// ### hfpa_pkg.sv
/*
 * Types shared by the host FIFO port block.
 * Assumes hfpa_map.svh for sizes.
 */
`include "hfpa_map.svh"

package hfpa_pkg;

	// One host access as seen after synchronising
	typedef struct packed {
		logic [`HFPA_AW-1:0] addr;
		logic [`HFPA_DW-1:0] wdata;
	} hfpa_req_t;

	// Size limits of the three sizable FIFOs
	typedef struct packed {
		logic [7:0] txd_lim;
		logic [7:0] rxs_lim;
		logic [7:0] rxd_lim;
	} hfpa_cfg_t;

	// Decoded target of a host access
	typedef enum logic [3:0] {
		P_NONE, P_RXD, P_TXD, P_RXS, P_RXS_VIEW, P_TXS, P_TXS_VIEW,
		P_CFG, P_EVT, P_LVL, P_SRST
	} hfpa_port_t;

	// Host access sequencer
	typedef enum logic [1:0] {
		ACC_IDLE, ACC_READ, ACC_WRITE
	} hfpa_acc_t;

endpackage

// ### hfpa_fifo.sv
/*
 * Shift-register FIFO with valid/ready on both sides and a run-time size limit.
 * Assumes one clock; clr is a synchronous clear; head sits in word zero.
 */
`timescale 1ns/10ps

module hfpa_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	localparam int CW   = $clog2(DEPTH + 1)
) (
	input  logic             clk,
	input  logic             clr,
	input  logic [CW-1:0]    limit,
	input  logic             in_valid,
	output logic             in_ready,
	input  logic [WIDTH-1:0] in_data,
	output logic             out_valid,
	input  logic             out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [CW-1:0]    level
);

	// Refuse sizes the shifter cannot serve
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("hfpa_fifo: DEPTH must be at least 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];     // Storage, head at index 0
	logic [WIDTH-1:0] nxt_mem [DEPTH];    // Next storage image
	logic [CW-1:0]    count_ff;           // Words held
	logic             full_ff;            // Registered full flag
	logic             valid_ff;           // Registered not-empty flag
	wire  [CW-1:0]    eff_lim;            // Usable depth
	wire              push;               // Word accepted
	wire              pop;                // Word drained
	wire  [CW-1:0]    nxt_count;          // Count after this cycle
	wire  [CW-1:0]    wr_idx;             // Slot for the new word

	// Zero or oversize limit means the full depth
	assign eff_lim   = (limit == '0 || limit > CW'(DEPTH)) ? CW'(DEPTH) : limit;
	assign push      = in_valid & ~full_ff;
	assign pop       = out_ready & valid_ff;
	assign nxt_count = CW'(count_ff + CW'(push) - CW'(pop));
	assign wr_idx    = pop ? CW'(count_ff - 1'b1) : count_ff;
	assign in_ready  = ~full_ff;
	assign out_valid = valid_ff;
	assign out_data  = mem_ff[0];
	assign level     = count_ff;

	// Shift on pop, drop new word behind the last one
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			nxt_mem[i] = (pop && i < DEPTH - 1) ? mem_ff[(i + 1) % DEPTH] : mem_ff[i];
			if (push && CW'(i) == wr_idx) begin
				nxt_mem[i] = in_data;
			end
		end
	end

	// Flags registered so ready and valid leave from flops
	always_ff @(posedge clk) begin
		if (clr) begin
			count_ff <= '0;
			full_ff  <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			full_ff  <= (nxt_count >= eff_lim);
			valid_ff <= (nxt_count != '0);
		end
	end

	// Storage needs no reset: flags guard every read
	always_ff @(posedge clk) begin
		mem_ff <= nxt_mem;
	end

endmodule

// ### hfpa_sticky.sv
/*
 * Sticky status bits with per-bit write-one-to-clear and clear-on-read.
 * Assumes one-cycle write and read strobes from the host sequencer.
 */
`timescale 1ns/10ps

module hfpa_sticky #(
	parameter int           W        = 4,
	parameter logic [W-1:0] W1C_MASK = '0,
	parameter logic [W-1:0] RC_MASK  = '0,
	parameter logic [W-1:0] RST_VAL  = '0
) (
	input  logic         clk,
	input  logic         clr,
	input  logic [W-1:0] set_ev,
	input  logic         wr_one,
	input  logic [W-1:0] wr_data,
	input  logic         rd_hit,
	output logic [W-1:0] bits
);

	if (W < 1) begin : g_bad_width
		$error("hfpa_sticky: W must be at least 1");
	end

	logic [W-1:0] bits_ff;      // Held flags
	wire  [W-1:0] clr_mask;     // Bits cleared this cycle
	wire  [W-1:0] nxt_bits;     // Next flags

	// Writing one clears, zero leaves alone; a read clears its own bits
	assign clr_mask = ({W{wr_one}} & wr_data & W1C_MASK) | ({W{rd_hit}} & RC_MASK);
	// Event in the clearing cycle survives: set wins
	assign nxt_bits = (bits_ff & ~clr_mask) | set_ev;
	assign bits     = bits_ff;

	// Flag store
	always_ff @(posedge clk) begin
		if (clr) begin
			bits_ff <= RST_VAL;
		end else begin
			bits_ff <= nxt_bits;
		end
	end

endmodule

// ### hfpa_check_properties.sv
/*
 * Port-level assertions for the host FIFO port block.
 * Assumes binding onto hfpa_host_fifo_port; one clock, rst synchronous high.
 */
`timescale 1ns/10ps
`include "hfpa_map.svh"

module hfpa_check #(
	parameter int DEPTH     = 32,
	parameter int STS_DEPTH = 32
) (
	input logic                clk,
	input logic                rst,
	input logic                host_cs_n,
	input logic                host_rd_n,
	input logic                host_wr_n,
	input logic [`HFPA_DW-1:0] host_data_out,
	input logic                host_data_oe,
	input logic                rx_data_valid,
	input logic                rx_data_ready,
	input logic                rx_sts_valid,
	input logic                rx_sts_ready,
	input logic                tx_sts_ready,
	input logic                tx_data_valid,
	input logic                tx_data_ready,
	input logic [`HFPA_DW-1:0] tx_data_out,
	input logic                mac_soft_reset
);
	// One clock domain
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Read port cleared while reset is applied
	out_clear_a: assert property (disable iff (1'b0) rst |=> !host_data_oe && host_data_out == '0)
		else $error("read port not cleared by reset");
	// FIFOs empty and pulse low after reset
	fifo_clear_a: assert property (disable iff (1'b0) rst |=> rx_data_ready && rx_sts_ready
		&& tx_sts_ready && !tx_data_valid && !mac_soft_reset)
		else $error("flags not at reset state");
	// Soft reset is a single-cycle pulse
	srst_pulse_a: assert property (mac_soft_reset |=> !mac_soft_reset)
		else $error("soft reset pulse too long");
	// Soft reset empties the transmit data FIFO
	srst_flush_a: assert property (mac_soft_reset |=> !tx_data_valid)
		else $error("soft reset left transmit data");
	// Soft reset only follows a host write
	srst_cause_a: assert property ($rose(mac_soft_reset) |-> $past(!host_wr_n && !host_cs_n, 2))
		else $error("soft reset without host write");
	// Read answer only after a read strobe
	oe_cause_a: assert property ($rose(host_data_oe) |-> $past(!host_rd_n && !host_cs_n, 3))
		else $error("read answer without read strobe");
	// Answer withdrawn once the strobe is gone
	oe_release_a: assert property (host_rd_n [*4] |=> !host_data_oe)
		else $error("read answer held after release");
	// Only a host write adds transmit data
	txd_push_a: assert property ($rose(tx_data_valid) |-> $past(!host_wr_n && !host_cs_n, 2))
		else $error("transmit data without host write");
	// Stalled head holds; reads never pop it
	txd_hold_a: assert property (tx_data_valid && !tx_data_ready && host_wr_n
		|=> tx_data_valid && $stable(tx_data_out))
		else $error("transmit head changed while stalled");
	// Host reads never fill the receive data FIFO
	rxd_fill_a: assert property (rx_data_ready && !rx_data_valid && host_wr_n |=> rx_data_ready)
		else $error("receive data filled without push");
	// Same for the receive status FIFO
	rxs_fill_a: assert property (rx_sts_ready && !rx_sts_valid && host_wr_n |=> rx_sts_ready)
		else $error("receive status filled without push");

	// Main scenarios reached
	cover property ($rose(host_data_oe));
	cover property (tx_data_valid && tx_data_ready);
	cover property ($rose(mac_soft_reset));
endmodule

bind hfpa_host_fifo_port hfpa_check #(.DEPTH(DEPTH), .STS_DEPTH(STS_DEPTH)) u_check (
	.clk(clk), .rst(rst), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
	.host_wr_n(host_wr_n), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
	.rx_data_valid(rx_data_valid), .rx_data_ready(rx_data_ready),
	.rx_sts_valid(rx_sts_valid), .rx_sts_ready(rx_sts_ready), .tx_sts_ready(tx_sts_ready),
	.tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready),
	.tx_data_out(tx_data_out), .mac_soft_reset(mac_soft_reset)
);

// ### hfpa_host_model.sv
/*
 * Host processor model on the SRAM-like bus: whole dword reads and writes.
 * Assumes the strobe timing of the block (3 cycles low, 3 high at least).
 */
`timescale 1ns/10ps
`include "hfpa_map.svh"

module hfpa_host_model (
	input  logic                clk,
	output logic                host_cs_n,
	output logic                host_rd_n,
	output logic                host_wr_n,
	output logic [`HFPA_AW-1:0] host_addr,
	output logic [`HFPA_DW-1:0] host_data_in,
	input  logic [`HFPA_DW-1:0] host_data_out,
	input  logic                host_data_oe
);
	// Idle bus at time zero
	initial begin
		{host_cs_n, host_rd_n, host_wr_n} = 3'h7;
		host_addr    = 8'h00;
		host_data_in = 32'h0;
	end

	// Released lines show the inverse, not a stale value
	task automatic release_bus();
		{host_cs_n, host_rd_n, host_wr_n} = 3'h7;
		host_addr    = ~host_addr;
		host_data_in = ~host_data_in;
		repeat (5) @(negedge clk);
	endtask

	// Read: hold strobe until answered
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk);
		host_addr = a;
		{host_cs_n, host_rd_n} = 2'h0;
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			if (host_data_oe === 1'b1) break;
		end
		d = host_data_out;
		release_bus();
	endtask

	// Write: only mapped ports, reserved bits left zero by callers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		host_addr    = a;
		host_data_in = d;
		{host_cs_n, host_wr_n} = 2'h0;
		repeat (4) @(negedge clk);
		release_bus();
	endtask
endmodule

// ### host_fifo_port_access_test.sv
/*
 * Self-checking bench for the host FIFO port block.
 * Assumes the host model for bus cycles; MAC sides driven here at negedge.
 */
`timescale 1ns/10ps
`include "hfpa_map.svh"

module host_fifo_port_access_test;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                host_cs_n, host_rd_n, host_wr_n, host_data_oe;
	logic [`HFPA_AW-1:0] host_addr;
	logic [`HFPA_DW-1:0] host_data_in, host_data_out, tx_data_out;
	logic                link_up = 1'b1;
	logic                rx_data_valid = 1'b0, rx_sts_valid = 1'b0, tx_sts_valid = 1'b0;
	logic [`HFPA_DW-1:0] rx_data_in = '0, rx_sts_in = '0, tx_sts_in = '0;
	logic                rx_data_ready, rx_sts_ready, tx_sts_ready;
	logic                tx_data_valid, mac_soft_reset, tx_data_ready = 1'b0;
	int                  n_errors = 0, check_count = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	hfpa_host_fifo_port uut (.clk(clk), .rst(rst), .host_cs_n(host_cs_n),
		.host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .link_up(link_up), .rx_data_valid(rx_data_valid),
		.rx_data_ready(rx_data_ready), .rx_data_in(rx_data_in), .rx_sts_valid(rx_sts_valid),
		.rx_sts_ready(rx_sts_ready), .rx_sts_in(rx_sts_in), .tx_sts_valid(tx_sts_valid),
		.tx_sts_ready(tx_sts_ready), .tx_sts_in(tx_sts_in), .tx_data_valid(tx_data_valid),
		.tx_data_ready(tx_data_ready), .tx_data_out(tx_data_out),
		.mac_soft_reset(mac_soft_reset));

	hfpa_host_model u_host (.clk(clk), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe));

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Host read then compare
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		u_host.rd(a, d);
		chk(nm, d, e);
	endtask

	// One MAC push: 0 rx data, 1 rx status, 2 tx status
	task automatic push(input int k, input logic [31:0] v);
		@(negedge clk);
		case (k)
			0: {rx_data_valid, rx_data_in} = {1'b1, v};
			1: {rx_sts_valid, rx_sts_in} = {1'b1, v};
			default: {tx_sts_valid, tx_sts_in} = {1'b1, v};
		endcase
		@(negedge clk);
		{rx_data_valid, rx_sts_valid, tx_sts_valid} = 3'h0;
		{rx_data_in, rx_sts_in, tx_sts_in} = ~{rx_data_in, rx_sts_in, tx_sts_in};
	endtask

	// Defaults straight after reset
	task automatic t_reset();
		chk("ready flags", {29'h0, rx_data_ready, rx_sts_ready, tx_sts_ready}, 32'h7);
		chk("idle outputs", {29'h0, tx_data_valid, host_data_oe, mac_soft_reset}, 32'h0);
		rc(`HFPA_CFG, 32'h0020_2020, "cfg default");
		rc(`HFPA_EVT, 32'h4, "evt default");
		rc(`HFPA_LVL, 32'h0, "levels empty");
	endtask

	// Status FIFO: view twice, pop twice, pop empty
	task automatic t_sts(input int k, input logic [7:0] pop, input logic [7:0] view);
		push(k, 32'h5a00_0001);
		push(k, 32'h5a00_0002);
		rc(view, 32'h5a00_0001, "view head");
		rc(view, 32'h5a00_0001, "view again");
		rc(pop, 32'h5a00_0001, "pop after view");
		rc(pop, 32'h5a00_0002, "pop second");
		rc(pop, 32'h0, "pop empty");
	endtask

	// Receive data over all aliases, underrun event
	task automatic t_rxd();
		for (int i = 0; i < 16; i++) push(0, 32'ha000_0000 + i);
		u_host.wr(8'h00, 32'h1234_5678);
		for (int i = 0; i < 16; i++) rc(8'(4 * i), 32'ha000_0000 + i, "rxd alias");
		rc(8'h3c, 32'h0, "rxd empty");
		rc(`HFPA_EVT, 32'h5, "underrun set");
		u_host.wr(`HFPA_EVT, 32'h0);
		rc(`HFPA_EVT, 32'h5, "w1c zero kept");
		u_host.wr(`HFPA_EVT, 32'h1);
		rc(`HFPA_EVT, 32'h4, "w1c one clears");
	endtask

	// Transmit data: overfill while stalled, drain
	task automatic t_txd();
		for (int i = 0; i < 33; i++) u_host.wr(8'h40 + 8'(4 * (i % 16)), 32'hc000_0000 + i);
		rc(`HFPA_LVL, 32'h20, "txd full level");
		rc(8'h44, 32'h0, "txd read zero");
		rc(`HFPA_EVT, 32'h6, "drop event");
		rc(`HFPA_EVT, 32'h4, "drop cleared");
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			chk("txd valid", {31'h0, tx_data_valid}, 32'h1);
			chk("txd word", tx_data_out, 32'hc000_0000 + i);
			tx_data_ready = 1'b1;
		end
		@(negedge clk);
		tx_data_ready = 1'b0;
		chk("txd drained", {31'h0, tx_data_valid}, 32'h0);
	endtask

	// Size limit, soft reset, read-only and write-only ports
	task automatic t_soft();
		u_host.wr(`HFPA_CFG, 32'h0010_1002);
		push(0, 32'h1);
		push(0, 32'h2);
		@(negedge clk);
		chk("rxd limit", {31'h0, rx_data_ready}, 32'h0);
		u_host.wr(`HFPA_SRST, 32'h1);
		chk("rxd flushed", {31'h0, rx_data_ready}, 32'h1);
		rc(`HFPA_CFG, 32'h0010_1002, "cfg kept");
		rc(`HFPA_SRST, 32'h0, "srst reads zero");
		for (int i = 0; i < 16; i++) push(1, i);
		u_host.wr(`HFPA_LVL, 32'hffff_ffff);
		u_host.wr(`HFPA_RXS_POP, 32'h1);
		rc(`HFPA_LVL, 32'h1000_0000, "levels untouched");
		rc(`HFPA_EVT, 32'hc, "rxs full latched");
		u_host.wr(`HFPA_SRST, 32'h1);
	endtask

	// Link drop latches low until read
	task automatic t_link();
		@(negedge clk);
		link_up = 1'b0;
		repeat (3) @(negedge clk);
		link_up = 1'b1;
		repeat (4) @(negedge clk);
		rc(`HFPA_EVT, 32'h0, "link latched");
		rc(`HFPA_EVT, 32'h4, "link released");
	endtask
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_sts(1, `HFPA_RXS_POP, `HFPA_RXS_VIEW);
		t_sts(2, `HFPA_TXS_POP, `HFPA_TXS_VIEW);
		t_rxd();
		t_txd();
		t_soft();
		t_link();
		wrap_up();
	end

	// Watchdog
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
endmodule
